// ### common/alif_map.svh
// Register offsets, field positions, reset values and timing counts of the axis limit/index block
`ifndef ALIF_MAP_SVH
`define ALIF_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ALIF_OFS_ENV1 5'h00
`define ALIF_OFS_ENV2 5'h04
`define ALIF_OFS_ENV3 5'h08
`define ALIF_OFS_SUBST 5'h0C
`define ALIF_OFS_EXTST 5'h10
`define ALIF_OFS_CMD 5'h14
`define ALIF_OFS_MSTAT 5'h18
`define ALIF_OFS_MPOS 5'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ALIF_ELM_BIT 3
`define ALIF_FLTR_BIT 26
`define ALIF_EZL_BIT 12
`define ALIF_EZD_LSB 0
`define ALIF_EZD_MSB 3
`define ALIF_POSLIM_BIT 12
`define ALIF_NEGLIM_BIT 13
`define ALIF_ORG_BIT 8
`define ALIF_INDEX_BIT 10
`define ALIF_CMD_OPC_MSB 7
`define ALIF_CMD_HS_BIT 8
`define ALIF_MST_BUSY_BIT 0
`define ALIF_MST_NSTOP_BIT 1
`define ALIF_MST_BADOP_BIT 2
`define ALIF_MST_CNT_LSB 4
`define ALIF_MST_CNT_MSB 8

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define ALIF_OP_FEED_POS 8'h20
`define ALIF_OP_FEED_NEG 8'h28
`define ALIF_OP_LEAVE_NEG 8'h22
`define ALIF_OP_LEAVE_POS 8'h2A
`define ALIF_OP_INDEX_POS 8'h24
`define ALIF_OP_INDEX_NEG 8'h2C
`define ALIF_OP_DIR_BIT 3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ALIF_ENV_RESET 32'h00000000
`define ALIF_CLK_MHZ 200
`define ALIF_FILTER_NS 4000
`define ALIF_FILTER_CYC ((`ALIF_FILTER_NS * `ALIF_CLK_MHZ + 999) / 1000)

`endif

// ### common/alif_pkg.sv
// Types shared by the axis limit/index block
package alif_pkg;

    // Kind of operation decoded from the operation code
    typedef enum logic [1:0] {
        ALIF_MD_NONE,
        ALIF_MD_FEED,
        ALIF_MD_LEAVE,
        ALIF_MD_INDEX
    } alif_mode_t;

    // Limit pair, positive and negative
    typedef struct packed {
        logic pos;
        logic neg;
    } alif_limit_t;

    // Commands toward the pulse generator
    typedef struct packed {
        logic run;
        logic dir_neg;
        logic high_speed;
        logic stop_now;
        logic stop_decel;
    } alif_drive_t;

endpackage

// ### core/alif_filter.sv
// Glitch filter for one synchronised sensor level
`timescale 1ns/1ps
`include "alif_map.svh"

module alif_filter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Level in, enable, filtered level out
    input wire logic level_in,
    input wire logic filter_en,
    output logic level_out
);

    logic [9:0] stable_reg;

    // ----------------------------------------
    // Level follows input once it held long enough
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= 1'b0;
            stable_reg <= 10'h000;
        end else if (!filter_en || level_in == level_out) begin
            level_out <= level_in;
            stable_reg <= 10'h000;
        end else if (stable_reg == 10'((`ALIF_FILTER_CYC) - 1)) begin
            level_out <= level_in; // RULE12
            stable_reg <= 10'h000;
        end else begin
            stable_reg <= stable_reg + 10'h001;
        end
    end

    // With the filter enabled, short pulses never reach the output
    filt_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        (filter_en && level_in != level_out && stable_reg < 10'((`ALIF_FILTER_CYC) - 1))
        |=> (level_out == $past(level_out)))
        else $error("filtered level changed early");

endmodule

// ### core/alif_index.sv
// Counts selected edges of the index input against a target
`timescale 1ns/1ps

module alif_index (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic index_level,
    input wire logic rising_sel,
    input wire logic count_clear,
    input wire logic count_en,
    input wire logic [3:0] target_m1,
    // Result
    output logic [4:0] index_count,
    output logic index_reached
);

    logic prev_reg;
    logic edge_seen;

    // Edge of the chosen polarity
    assign edge_seen = rising_sel ? (index_level & ~prev_reg) : (~index_level & prev_reg); // RULE17
    assign index_reached = (index_count == ({1'b0, target_m1} + 5'h01)); // RULE13 RULE15

    // ----------------------------------------
    // Edge history
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= index_level;
        end
    end

    // ----------------------------------------
    // Edge counter
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_count <= 5'h00;
        end else if (count_clear) begin
            index_count <= 5'h00; // RULE20
        end else if (count_en && edge_seen && !index_reached) begin
            index_count <= index_count + 5'h01;
        end
    end

    // A rising edge advances the count when rising edges are selected
    edge_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
        (count_en && !count_clear && !index_reached && rising_sel && !prev_reg && index_level)
        |=> (index_count == $past(index_count) + 5'h01))
        else $error("rising index edge not counted");

endmodule

// ### core/alif_top.sv
// Axis feed-to-limit, leave-limit and index-count logic with Avalon-MM registers
`timescale 1ns/1ps
`include "alif_map.svh"

// How it works
// RULE1 - Code 20h feeds positive to limit, stops
// RULE2 - Code 28h feeds negative to limit, stops
// RULE3 - Code 22h moves positive off negative limit
// RULE4 - Code 2Ah moves negative off positive limit
// RULE5 - Feed start at active limit: no run
// RULE6 - Feed stops when either limit activates
// RULE7 - Leave start with limits clear: no run
// RULE8 - Leave stops once both limits clear
// RULE9 - Polarity pin low: active high limits
// RULE10 - Limit stop bit: immediate or decelerate
// RULE11 - Sub status bits 12,13 show limits
// RULE12 - Filter bit drops pulses under four microseconds
// RULE13 - Codes 24h/2Ch feed until count+1 edges
// RULE14 - Index stop: immediate constant, decel high
// RULE15 - Four-bit count field holds target minus one
// RULE16 - Host uses constant speed for index feeds
// RULE17 - Edge select bit: falling or rising
// RULE18 - Extension status bit 10 shows index
// RULE19 - Position counter tracks true axis position
// RULE20 - Index counter cleared at index start
module alif_top
    import alif_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Sensor pins
    input wire logic end_limit_input_pos,
    input wire logic end_limit_input_neg,
    input wire logic origin_input,
    input wire logic encoder_index_input,
    input wire logic limit_polarity_pin,
    // Software limit levels from the position compare logic
    input wire alif_limit_t soft_travel_limit,
    // Pulse generator side
    input wire logic gen_idle,
    input wire logic step_pulse,
    input wire logic step_dir_neg,
    output alif_drive_t drive
);

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} alif_state_t;

    logic [4:0] pin_sync1_reg;
    logic [4:0] pin_sync2_reg;
    logic lim_pos_raw;
    logic lim_neg_raw;
    alif_limit_t end_lim;
    logic origin_flt;
    logic [31:0] env1_reg;
    logic [31:0] env2_reg;
    logic [31:0] env3_reg;
    logic ack_reg;
    logic bus_take;
    logic wr_take;
    logic [31:0] rd_next;
    logic [27:0] mech_pos_reg;
    alif_state_t state_reg;
    alif_mode_t mode_reg;
    logic dir_neg_reg;
    logic high_speed_reg;
    logic normal_stop_reg;
    logic bad_op_reg;
    logic start_take;
    alif_mode_t start_mode;
    logic start_dir;
    logic start_hit;
    logic run_hit;
    logic run_done;
    logic run_decel;
    logic [4:0] idx_count;
    logic idx_reached;
    logic stop_set;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Operation code to kind
    function automatic alif_mode_t alif_decode(input logic [7:0] code);
        case (code)
            `ALIF_OP_FEED_POS, `ALIF_OP_FEED_NEG: alif_decode = ALIF_MD_FEED;
            `ALIF_OP_LEAVE_NEG, `ALIF_OP_LEAVE_POS: alif_decode = ALIF_MD_LEAVE;
            `ALIF_OP_INDEX_POS, `ALIF_OP_INDEX_NEG: alif_decode = ALIF_MD_INDEX;
            default: alif_decode = ALIF_MD_NONE;
        endcase
    endfunction

    // Limit of the pair that matters for a mode and direction
    function automatic logic alif_watch(input alif_mode_t md, input logic neg, input alif_limit_t lim);
        logic toward_neg;
        toward_neg = (md == ALIF_MD_LEAVE) ? ~neg : neg;
        alif_watch = toward_neg ? lim.neg : lim.pos;
    endfunction

    // Byte-lane merge for writable words
    function automatic logic [31:0] alif_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        alif_merge = res;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync1_reg <= 5'h00;
            pin_sync2_reg <= 5'h00;
        end else begin
            pin_sync1_reg <= {limit_polarity_pin, encoder_index_input, origin_input,
                              end_limit_input_neg, end_limit_input_pos};
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // Polarity pin high turns limits active low
    assign lim_pos_raw = pin_sync2_reg[0] ^ pin_sync2_reg[4]; // RULE9
    assign lim_neg_raw = pin_sync2_reg[1] ^ pin_sync2_reg[4]; // RULE9

    // ----------------------------------------
    // Limit and origin filters
    // ----------------------------------------
    alif_filter u_flt_pos (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .level_in(lim_pos_raw),
        .filter_en(env1_reg[`ALIF_FLTR_BIT]),
        .level_out(end_lim.pos)
    );

    alif_filter u_flt_neg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .level_in(lim_neg_raw),
        .filter_en(env1_reg[`ALIF_FLTR_BIT]),
        .level_out(end_lim.neg)
    );

    alif_filter u_flt_org (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .level_in(pin_sync2_reg[2]),
        .filter_en(env1_reg[`ALIF_FLTR_BIT]),
        .level_out(origin_flt)
    );

    // ----------------------------------------
    // Index edge counter
    // ----------------------------------------
    alif_index u_index (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .index_level(pin_sync2_reg[3]),
        .rising_sel(env2_reg[`ALIF_EZL_BIT]),
        .count_clear(start_take && start_mode == ALIF_MD_INDEX),
        .count_en(state_reg == ST_RUN && mode_reg == ALIF_MD_INDEX),
        .target_m1(env3_reg[`ALIF_EZD_MSB:`ALIF_EZD_LSB]),
        .index_count(idx_count),
        .index_reached(idx_reached)
    );

    // ----------------------------------------
    // Bus handshake, one wait cycle per access
    // ----------------------------------------
    assign bus_take = (avs_read || avs_write) && !ack_reg;
    assign wr_take = avs_write && ack_reg;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign start_take = wr_take && avs_address == `ALIF_OFS_CMD && state_reg == ST_IDLE
                        && avs_byteenable[0];
    assign start_mode = alif_decode(avs_writedata[`ALIF_CMD_OPC_MSB:0]);
    assign start_dir = avs_writedata[`ALIF_OP_DIR_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_take;
        end
    end

    // Read mux, unmapped reads return zero
    always_comb begin
        rd_next = 32'h00000000;
        case (avs_address)
            `ALIF_OFS_ENV1: rd_next = env1_reg;
            `ALIF_OFS_ENV2: rd_next = env2_reg;
            `ALIF_OFS_ENV3: rd_next = env3_reg;
            `ALIF_OFS_SUBST: begin
                rd_next[`ALIF_POSLIM_BIT] = end_lim.pos; // RULE11
                rd_next[`ALIF_NEGLIM_BIT] = end_lim.neg; // RULE11
            end
            `ALIF_OFS_EXTST: begin
                rd_next[`ALIF_INDEX_BIT] = pin_sync2_reg[3]; // RULE18
                rd_next[`ALIF_ORG_BIT] = origin_flt;
            end
            `ALIF_OFS_CMD: begin
                rd_next[`ALIF_CMD_OPC_MSB:0] = {4'h2, dir_neg_reg, 3'h0} | {6'h00, mode_reg};
                rd_next[`ALIF_CMD_HS_BIT] = high_speed_reg;
            end
            `ALIF_OFS_MSTAT: begin
                rd_next[`ALIF_MST_BUSY_BIT] = (state_reg != ST_IDLE);
                rd_next[`ALIF_MST_NSTOP_BIT] = normal_stop_reg;
                rd_next[`ALIF_MST_BADOP_BIT] = bad_op_reg;
                rd_next[`ALIF_MST_CNT_MSB:`ALIF_MST_CNT_LSB] = idx_count;
            end
            `ALIF_OFS_MPOS: rd_next = {4'h0, mech_pos_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_take && avs_read) begin
            avs_readdata <= rd_next;
        end
    end

    // ----------------------------------------
    // Environment registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            env1_reg <= `ALIF_ENV_RESET;
            env2_reg <= `ALIF_ENV_RESET;
            env3_reg <= `ALIF_ENV_RESET;
        end else if (wr_take) begin
            if (avs_address == `ALIF_OFS_ENV1) begin
                env1_reg <= alif_merge(env1_reg, avs_writedata, avs_byteenable);
            end
            if (avs_address == `ALIF_OFS_ENV2) begin
                env2_reg <= alif_merge(env2_reg, avs_writedata, avs_byteenable);
            end
            if (avs_address == `ALIF_OFS_ENV3) begin
                env3_reg <= alif_merge(env3_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // ----------------------------------------
    // Mechanical position counter
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mech_pos_reg <= 28'h0000000;
        end else if (step_pulse) begin
            // Counts every emitted pulse, including decel overrun
            mech_pos_reg <= step_dir_neg ? mech_pos_reg - 28'h0000001 : mech_pos_reg + 28'h0000001; // RULE19
        end
    end

    // ----------------------------------------
    // Limit evaluation
    // ----------------------------------------
    assign start_hit = alif_watch(start_mode, start_dir, end_lim)
                       || alif_watch(start_mode, start_dir, soft_travel_limit);
    assign run_hit = alif_watch(mode_reg, dir_neg_reg, end_lim)
                     || alif_watch(mode_reg, dir_neg_reg, soft_travel_limit);

    // Stop conditions while running
    always_comb begin
        run_done = 1'b0;
        run_decel = high_speed_reg; // RULE14
        case (mode_reg)
            ALIF_MD_FEED: begin
                run_done = run_hit; // RULE1 RULE2 RULE6
                if (alif_watch(mode_reg, dir_neg_reg, end_lim)) begin
                    run_decel = env1_reg[`ALIF_ELM_BIT]; // RULE10
                end
            end
            ALIF_MD_LEAVE: run_done = !run_hit; // RULE3 RULE4 RULE8
            ALIF_MD_INDEX: run_done = idx_reached; // RULE13
            default: run_done = 1'b1;
        endcase
    end

    // ----------------------------------------
    // Operation sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            mode_reg <= ALIF_MD_NONE;
            dir_neg_reg <= 1'b0;
            high_speed_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_take && start_mode != ALIF_MD_NONE) begin
                        mode_reg <= start_mode;
                        dir_neg_reg <= start_dir;
                        high_speed_reg <= avs_writedata[`ALIF_CMD_HS_BIT];
                        if (start_mode == ALIF_MD_FEED && start_hit) begin
                            state_reg <= ST_IDLE; // RULE5
                        end else if (start_mode == ALIF_MD_LEAVE && !start_hit) begin
                            state_reg <= ST_IDLE; // RULE7
                        end else begin
                            state_reg <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (run_done) begin
                        state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (gen_idle) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Normal stop seen at a refused start or end of a run
    assign stop_set = (start_take && start_mode == ALIF_MD_FEED && start_hit)
                      || (start_take && start_mode == ALIF_MD_LEAVE && !start_hit)
                      || (state_reg == ST_STOP && gen_idle);

    // ----------------------------------------
    // Status flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_stop_reg <= 1'b0;
            bad_op_reg <= 1'b0;
        end else begin
            if (stop_set) begin
                normal_stop_reg <= 1'b1; // RULE5 RULE7
            end else if (start_take || (wr_take && avs_address == `ALIF_OFS_MSTAT
                         && avs_writedata[`ALIF_MST_NSTOP_BIT])) begin
                normal_stop_reg <= 1'b0;
            end
            if (start_take && start_mode == ALIF_MD_NONE) begin
                bad_op_reg <= 1'b1;
            end else if (start_take || (wr_take && avs_address == `ALIF_OFS_MSTAT
                         && avs_writedata[`ALIF_MST_BADOP_BIT])) begin
                bad_op_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Drive outputs toward the pulse generator
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive <= '0;
        end else begin
            drive.run <= (state_reg == ST_RUN) && !run_done;
            drive.dir_neg <= dir_neg_reg;
            drive.high_speed <= high_speed_reg;
            drive.stop_now <= (state_reg == ST_RUN) && run_done && !run_decel; // RULE10 RULE14
            drive.stop_decel <= (state_reg == ST_RUN) && run_done && run_decel; // RULE10 RULE14
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    feed_refuse_a: assert property ((start_take && start_mode == ALIF_MD_FEED && start_hit) // RULE5
        |=> (state_reg == ST_IDLE && normal_stop_reg) ##1 !drive.run)
        else $error("feed started into an active limit");

    leave_refuse_a: assert property ((start_take && start_mode == ALIF_MD_LEAVE && !start_hit) // RULE7
        |=> (state_reg == ST_IDLE && normal_stop_reg) ##1 !drive.run)
        else $error("leave started with limits clear");

    feed_stop_a: assert property ((state_reg == ST_RUN && mode_reg == ALIF_MD_FEED && run_hit) // RULE6
        |=> (!drive.run && (drive.stop_now || drive.stop_decel)))
        else $error("feed kept running at limit");

    leave_stop_a: assert property ((state_reg == ST_RUN && mode_reg == ALIF_MD_LEAVE && run_hit) // RULE8
        |=> drive.run)
        else $error("leave stopped while a limit is active");

    limit_method_a: assert property ((state_reg == ST_RUN && mode_reg == ALIF_MD_FEED // RULE10
        && alif_watch(mode_reg, dir_neg_reg, end_lim))
        |=> (drive.stop_decel == $past(env1_reg[`ALIF_ELM_BIT])))
        else $error("limit stop method ignored");

    idx_stop_a: assert property ((state_reg == ST_RUN && mode_reg == ALIF_MD_INDEX && idx_reached) // RULE14
        |=> (drive.stop_now != $past(high_speed_reg)) ##1 (state_reg != ST_RUN))
        else $error("index stop method wrong");

    idx_clear_a: assert property ((start_take && start_mode == ALIF_MD_INDEX) // RULE20
        |=> (idx_count == 5'h00))
        else $error("index count not cleared at start");

    sub_read_a: assert property ((bus_take && avs_read && avs_address == `ALIF_OFS_SUBST) // RULE11
        |=> (avs_readdata[`ALIF_NEGLIM_BIT:`ALIF_POSLIM_BIT] == $past({end_lim.neg, end_lim.pos})))
        else $error("limit sub status mismatch");

    bus_wait_a: assert property ((avs_read || avs_write) && !ack_reg
        |=> !avs_waitrequest)
        else $error("waitrequest held too long");

endmodule

// ### verif/alif_motor_model.sv
// Pulse generator stand-in driven by the drive bundle
`timescale 1ns/1ps
module alif_motor_model
    import alif_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Drive bundle in, generator status out
    input wire alif_drive_t drive,
    output logic gen_idle,
    output logic step_pulse,
    output logic step_dir_neg
);
    logic [3:0] div_reg;
    // One pulse every four cycles, idle again up to 16 cycles after run drops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 4'h0;
            step_pulse <= 1'b0;
            step_dir_neg <= 1'b0;
            gen_idle <= 1'b1;
        end else begin
            div_reg <= div_reg + 4'h1;
            step_pulse <= drive.run && (div_reg[1:0] == 2'h0);
            step_dir_neg <= drive.dir_neg;
            if (drive.run) begin
                gen_idle <= 1'b0;
            end else if (div_reg == 4'hF) begin
                gen_idle <= 1'b1;
            end
        end
    end
endmodule

// ### verif/alif_top_tb_top.sv
// Self-checking bench for the axis limit and index block
`timescale 1ns/1ps
`include "alif_map.svh"
module alif_top_tb_top
    import alif_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, p0;
    logic [3:0] avs_byteenable = 4'hF;
    logic end_limit_input_pos = 1'b0, end_limit_input_neg = 1'b0, origin_input = 1'b0;
    logic encoder_index_input = 1'b0, limit_polarity_pin = 1'b0, gen_idle, step_pulse, step_dir_neg;
    alif_limit_t soft_travel_limit = '0;
    alif_drive_t drive;
    logic [27:0] pcnt = 28'h0;
    int error_cnt = 0, compares = 0;
    alif_top i_alif_top (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .end_limit_input_pos, .end_limit_input_neg,
        .origin_input, .encoder_index_input, .limit_polarity_pin, .soft_travel_limit, .gen_idle,
        .step_pulse, .step_dir_neg, .drive);
    alif_motor_model i_alif_motor_model (.ref_clk, .rst_n, .drive, .gen_idle, .step_pulse, .step_dir_neg);
    // Clock and expected position
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (step_pulse) pcnt <= step_dir_neg ? pcnt - 28'h1 : pcnt + 28'h1;
    task automatic stop_test;
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) error_cnt++;
        if (n == 20) stop_test();
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic go(input logic [31:0] c);
        bus(1'b1, `ALIF_OFS_MSTAT, 32'h6);
        p0 = pcnt;
        bus(1'b1, `ALIF_OFS_CMD, c);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // Poll until idle, then expect a normal stop and a matching position
    task automatic idle(input string n);
        int k;
        for (k = 0; k < 100; k++) begin
            bus(1'b0, `ALIF_OFS_MSTAT, 32'h0);
            if (q[0] === 1'b0) break;
        end
        if (k == 100) error_cnt++;
        if (k == 100) stop_test();
        chk(n, q[1], 1'b1);
        wt(4);
        bus(1'b0, `ALIF_OFS_MPOS, 32'h0);
        chk("position", q[27:0], pcnt);
        bus(1'b0, `ALIF_OFS_MSTAT, 32'h0);
    endtask
    task automatic run_is(input logic r, input logic d);
        chk("run", {drive.run, drive.dir_neg}, {r, d});
    endtask
    initial begin
        wt(16);
        rst_n <= 1'b1;
        bus(1'b0, `ALIF_OFS_ENV1, 32'h0);
        chk("env1", q, `ALIF_ENV_RESET);
        // Limit sense and sub status
        end_limit_input_pos <= 1'b1;
        wt(8);
        bus(1'b0, `ALIF_OFS_SUBST, 32'h0);
        chk("sub_hi", q[13:12], 2'h1);
        limit_polarity_pin <= 1'b1;
        wt(8);
        bus(1'b0, `ALIF_OFS_SUBST, 32'h0);
        chk("sub_lo", q[13:12], 2'h2);
        limit_polarity_pin <= 1'b0;
        end_limit_input_pos <= 1'b0;
        wt(8);
        // Feed to limits and refused feed
        go(32'h20);
        wt(30);
        run_is(1'b1, 1'b0);
        end_limit_input_pos <= 1'b1;
        idle("feed_pos");
        go(32'h20);
        idle("feed_refused");
        chk("no_pulses", pcnt, p0);
        // Leave needs both hardware and soft limit clear
        soft_travel_limit.pos <= 1'b1;
        go(32'h2A);
        wt(30);
        end_limit_input_pos <= 1'b0;
        wt(20);
        run_is(1'b1, 1'b1);
        soft_travel_limit.pos <= 1'b0;
        idle("leave_pos");
        go(32'h22);
        idle("leave_refused");
        chk("no_pulses", pcnt, p0);
        go(32'h28);
        wt(30);
        run_is(1'b1, 1'b1);
        soft_travel_limit.neg <= 1'b1;
        idle("feed_neg");
        go(32'h22);
        wt(30);
        run_is(1'b1, 1'b0);
        soft_travel_limit.neg <= 1'b0;
        idle("leave_neg");
        // Index count: rising edges, two of them, constant speed start
        bus(1'b1, `ALIF_OFS_ENV2, 32'h1000);
        bus(1'b1, `ALIF_OFS_ENV3, 32'h1);
        go(32'h24);
        repeat (2) begin
            wt(20);
            encoder_index_input <= 1'b1;
            wt(10);
            bus(1'b0, `ALIF_OFS_EXTST, 32'h0);
            chk("index_flag", q[10], 1'b1);
            encoder_index_input <= 1'b0;
        end
        run_is(1'b0, 1'b0);
        idle("index_pos");
        chk("index_cnt", q[8:4], 5'h2);
        // Falling edge, one edge, counter restarts from zero
        bus(1'b1, `ALIF_OFS_ENV2, 32'h0);
        bus(1'b1, `ALIF_OFS_ENV3, 32'h0);
        go(32'h2C);
        wt(20);
        encoder_index_input <= 1'b1;
        wt(8);
        run_is(1'b1, 1'b1);
        encoder_index_input <= 1'b0;
        idle("index_neg");
        chk("index_cnt", q[8:4], 5'h1);
        stop_test();
    end
endmodule
